// *** hw/camera_capability_inquiry_regs.sv ***
// Read-only capability inquiry words of the camera, answering quadlet requests.
// Assumes the serial bus link hands over requests on mclk_in, one per cycle at most.
// Operation
// R1: The 1280x960 16-bit mono rate word shows 1.875, 3.75 and 7.5 fps supported, 15/30/60 fps not.
// R2: The 1600x1200 16-bit mono rate word shows the same three low rates and zero for the higher ones.
// R3: The custom mode 0 word returns all 32 bits of that mode's quadlet offset; every model has it.
// R4: The custom mode 1 word returns that mode's quadlet offset on the colour model.
// R5: Each single-bit flag of the basic-function word is one when available and zero when not.
// R6: Bits 0 to 3 of the basic-function word report vendor extensions, two error registers and extras.
// R7: The fast bus capability at bit 8 and power control at bit 16 read zero.
// R8: Single capture at bit 19 reads one and multiple capture at bit 20 reads zero.
// R9: Bits 28 to 31 of the basic-function word hold the highest setting slot number, which is 3.
// R10: Host software reads a zero slot field as no stored setting slots at all.
// R11: All inquiry words are constants, writes are ignored and reserved bits read zero.
`timescale 1ns/1ns
`include "inq_params.svh"

module camera_capability_inquiry_regs
#(
  parameter int          ADDR_W       = 12,
  parameter logic [31:0] CUSTOM0_OFS  = `CUSTOM0_OFS_DEFAULT,
  parameter logic [31:0] CUSTOM1_OFS  = `CUSTOM1_OFS_DEFAULT,
  parameter bit          COLOUR_MODEL = 1'b0
)
(
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              sys_rst_in,
  // Quadlet request
  input  wire logic              req_valid_in,
  input  wire logic              req_write_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  // Answer
  output logic                   resp_valid_out,
  output logic                   resp_write_out,
  output logic                   resp_error_out,
  output logic [31:0]            resp_rdata_out
);

  // Offsets must be reachable with the address width in use
  generate
    if (ADDR_W < 11 || ADDR_W > 32)
    begin : g_bad_width
      $error("ADDR_W must lie between 11 and 32");
    end
    if (CUSTOM0_OFS == `WORD_ZERO)
    begin : g_bad_ofs
      $error("CUSTOM0_OFS must be nonzero, mode 0 is always present");
    end
  endgenerate

  // Mask with one field bit set, field bits counted from the top
  function automatic logic [31:0] doc_bit(input int pos);
    logic [31:0] m;
    m = `WORD_ZERO;
    m[31-pos] = 1'b1;
    return m;
  endfunction

  // Decode a byte address to an inquiry word
  function automatic inq_pkg::inq_sel_t decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] o;
    o = a;
    unique case (o)
      ADDR_W'(`OFS_RATE_SUPPORT_MONO16_MID):   return inq_pkg::SEL_RATE_MID;
      ADDR_W'(`OFS_RATE_SUPPORT_MONO16_HIGH):  return inq_pkg::SEL_RATE_HIGH;
      ADDR_W'(`OFS_CUSTOM_MODE0_BLOCK_OFFSET): return inq_pkg::SEL_CUSTOM0;
      ADDR_W'(`OFS_CUSTOM_MODE1_BLOCK_OFFSET): return inq_pkg::SEL_CUSTOM1;
      ADDR_W'(`OFS_BASIC_FUNCTION_PRESENCE):   return inq_pkg::SEL_BASIC;
      default:                                 return inq_pkg::SEL_NONE;
    endcase
  endfunction

  // Both rate words carry the same three low rates
  localparam logic [31:0] RATE_WORD =
    doc_bit(`RATE_BIT_1P875) | doc_bit(`RATE_BIT_3P75) | doc_bit(`RATE_BIT_7P5); // R1 R2

  // Flags are set only for functions present; fast bus, power and multi capture stay zero
  localparam logic [31:0] BASIC_FLAGS =
    doc_bit(`BF_BIT_VENDOR_EXT) | doc_bit(`BF_BIT_VMODE_ERR_STATUS) |
    doc_bit(`BF_BIT_FEATURE_ERR_STATUS) | doc_bit(`BF_BIT_EXTRA_FUNCTION_REGS) |
    doc_bit(`BF_BIT_SINGLE_CAPTURE); // R5 R6 R7 R8

  // Slot field sits at the least significant nibble
  localparam logic [31:0] BASIC_WORD = BASIC_FLAGS | {28'h000_0000, `BF_SLOT_MAX}; // R9

  // Mono model reports mode 1 absent with a zero offset
  localparam logic [31:0] MODE1_WORD = COLOUR_MODEL ? CUSTOM1_OFS : `WORD_ZERO; // R4

  // Rate words, one per fixed 16-bit mono mode
  logic [31:0] rate_word [2];
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_rate
      assign rate_word[gi] = RATE_WORD; // R1 R2
    end
  endgenerate

  // Answer state
  logic        resp_valid;
  logic        resp_write;
  logic        resp_error;
  logic [31:0] resp_rdata;
  logic        next_resp_valid;
  logic        next_resp_write;
  logic        next_resp_error;
  logic [31:0] next_resp_rdata;

  inq_pkg::inq_sel_t req_sel;

  assign req_sel = decode(req_addr_in);

  always_comb
  begin
    next_resp_valid = req_valid_in;
    next_resp_write = req_valid_in & req_write_in;
    next_resp_error = req_valid_in & (req_sel == inq_pkg::SEL_NONE);
    next_resp_rdata = `WORD_ZERO;
    // Writes store nothing and return zero, the words are fixed in logic
    if (req_valid_in && !req_write_in)
    begin
      unique case (req_sel)
        inq_pkg::SEL_RATE_MID:  next_resp_rdata = rate_word[0];  // R1
        inq_pkg::SEL_RATE_HIGH: next_resp_rdata = rate_word[1];  // R2
        inq_pkg::SEL_CUSTOM0:   next_resp_rdata = CUSTOM0_OFS;   // R3
        inq_pkg::SEL_CUSTOM1:   next_resp_rdata = MODE1_WORD;    // R4
        inq_pkg::SEL_BASIC:     next_resp_rdata = BASIC_WORD;    // R5 R6 R7 R8 R9
        inq_pkg::SEL_NONE:      next_resp_rdata = `WORD_ZERO;    // R11
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      resp_valid <= 1'b0;
      resp_write <= 1'b0;
      resp_error <= 1'b0;
      resp_rdata <= `WORD_ZERO;
    end
    else
    begin
      resp_valid <= next_resp_valid;
      resp_write <= next_resp_write;
      resp_error <= next_resp_error;
      resp_rdata <= next_resp_rdata;
    end
  end

  assign resp_valid_out = resp_valid;
  assign resp_write_out = resp_write;
  assign resp_error_out = resp_error;
  assign resp_rdata_out = resp_rdata;

  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  property p_rate_mid;
    req_valid_in && !req_write_in && req_addr_in == ADDR_W'(`OFS_RATE_SUPPORT_MONO16_MID)
    |=> resp_valid_out && !resp_error_out && resp_rdata_out == 32'hE000_0000;
  endproperty
  a_rate_mid: assert property (p_rate_mid) else $error("mid rate word wrong"); // R1

  property p_rate_high;
    req_valid_in && !req_write_in && req_addr_in == ADDR_W'(`OFS_RATE_SUPPORT_MONO16_HIGH)
    |=> resp_valid_out && resp_rdata_out[31:29] == 3'h7 && resp_rdata_out[28:0] == 29'h0000_0000;
  endproperty
  a_rate_high: assert property (p_rate_high) else $error("high rate word wrong"); // R2

  property p_custom0;
    req_valid_in && !req_write_in && req_addr_in == ADDR_W'(`OFS_CUSTOM_MODE0_BLOCK_OFFSET)
    |=> resp_rdata_out == CUSTOM0_OFS && resp_rdata_out != 32'h0000_0000;
  endproperty
  a_custom0: assert property (p_custom0) else $error("mode 0 offset wrong"); // R3

  property p_custom1;
    req_valid_in && !req_write_in && req_addr_in == ADDR_W'(`OFS_CUSTOM_MODE1_BLOCK_OFFSET)
    |=> resp_valid_out && (COLOUR_MODEL ? resp_rdata_out == CUSTOM1_OFS : resp_rdata_out == 32'h0000_0000);
  endproperty
  a_custom1: assert property (p_custom1) else $error("mode 1 offset wrong"); // R4

  sequence s_basic_read;
    req_valid_in && !req_write_in && req_addr_in == ADDR_W'(`OFS_BASIC_FUNCTION_PRESENCE);
  endsequence

  property p_basic_flags;
    s_basic_read |=> resp_rdata_out[27:4] == 24'h00_0100 && !resp_error_out;
  endproperty
  a_basic_flags: assert property (p_basic_flags) else $error("basic flags wrong"); // R5

  property p_basic_present;
    s_basic_read |=> resp_rdata_out[31:28] == 4'hF;
  endproperty
  a_basic_present: assert property (p_basic_present) else $error("presence bits 0..3 wrong"); // R6

  property p_basic_absent;
    s_basic_read |=> !resp_rdata_out[23] && !resp_rdata_out[15];
  endproperty
  a_basic_absent: assert property (p_basic_absent) else $error("fast bus or power bit set"); // R7

  property p_basic_capture;
    s_basic_read |=> resp_rdata_out[12] && !resp_rdata_out[11];
  endproperty
  a_basic_capture: assert property (p_basic_capture) else $error("capture bits wrong"); // R8

  property p_basic_slots;
    s_basic_read |=> resp_rdata_out[3:0] == 4'h3;
  endproperty
  a_basic_slots: assert property (p_basic_slots) else $error("slot field wrong"); // R9

  property p_write_ignored;
    req_valid_in && req_write_in
    |=> resp_valid_out && resp_write_out && resp_rdata_out == 32'h0000_0000;
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("write not ignored"); // R11

  property p_write_then_read;
    req_valid_in && req_write_in && req_addr_in == ADDR_W'(`OFS_BASIC_FUNCTION_PRESENCE)
    ##1 s_basic_read |=> resp_rdata_out == 32'hF000_1003;
  endproperty
  a_write_then_read: assert property (p_write_then_read) else $error("write altered word"); // R11

  property p_unmapped;
    req_valid_in && decode(req_addr_in) == inq_pkg::SEL_NONE
    |=> resp_valid_out && resp_error_out && resp_rdata_out == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped answer wrong"); // R11

  property p_no_spurious;
    !req_valid_in |=> !resp_valid_out && !resp_error_out && !resp_write_out;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("answer without request");

  // Answer timing: every taken request gets exactly one answer on the next edge
  property p_answer_follows;
    req_valid_in |=> resp_valid_out;
  endproperty
  a_answer_follows: assert property (p_answer_follows) else $error("request left unanswered");

  // Data must fall back to zero between answers, the host may latch it late
  property p_idle_data;
    !req_valid_in |=> resp_rdata_out == 32'h0000_0000;
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("data shown without answer"); // R11

  // Rates above 7.5 fps and all reserved rate bits read zero
  property p_rate_unsupported;
    req_valid_in && !req_write_in &&
    (req_addr_in == ADDR_W'(`OFS_RATE_SUPPORT_MONO16_MID) ||
     req_addr_in == ADDR_W'(`OFS_RATE_SUPPORT_MONO16_HIGH))
    |=> resp_rdata_out[28:26] == 3'h0 && resp_rdata_out[25:0] == 26'h000_0000;
  endproperty
  a_rate_unsupported: assert property (p_rate_unsupported) else $error("rate bit set wrongly"); // R1 R2

  property p_custom0_ok;
    req_valid_in && !req_write_in && req_addr_in == ADDR_W'(`OFS_CUSTOM_MODE0_BLOCK_OFFSET)
    |=> resp_valid_out && !resp_error_out && !resp_write_out;
  endproperty
  a_custom0_ok: assert property (p_custom0_ok) else $error("mode 0 read flagged"); // R3

  property p_mapped_read;
    req_valid_in && !req_write_in && decode(req_addr_in) != inq_pkg::SEL_NONE
    |=> resp_valid_out && !resp_error_out && !resp_write_out;
  endproperty
  a_mapped_read: assert property (p_mapped_read) else $error("mapped read answered wrongly"); // R11

  property p_mapped_write;
    req_valid_in && req_write_in && decode(req_addr_in) != inq_pkg::SEL_NONE
    |=> resp_valid_out && resp_write_out && !resp_error_out;
  endproperty
  a_mapped_write: assert property (p_mapped_write) else $error("mapped write answered wrongly"); // R11

  property p_unmapped_write;
    req_valid_in && req_write_in && decode(req_addr_in) == inq_pkg::SEL_NONE
    |=> resp_valid_out && resp_write_out && resp_error_out;
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write not flagged"); // R11

  // Reserved positions of the basic-function word stay clear
  property p_basic_reserved;
    s_basic_read |=> resp_rdata_out[27:24] == 4'h0 && resp_rdata_out[22:16] == 7'h00 &&
                     resp_rdata_out[14:13] == 2'h0 && resp_rdata_out[10:4] == 7'h00;
  endproperty
  a_basic_reserved: assert property (p_basic_reserved) else $error("reserved basic bit set"); // R11

  // A zero slot field would tell the host there are no slots at all
  property p_slot_nonzero;
    s_basic_read |=> resp_rdata_out[3:0] != 4'h0;
  endproperty
  a_slot_nonzero: assert property (p_slot_nonzero) else $error("slot field reads zero"); // R9

  // One check per single-bit flag, so a slip in the bit order names its position
  localparam int          FLAG_NUM           = 8;
  localparam int          FLAG_POS[FLAG_NUM] = '{`BF_BIT_VENDOR_EXT, `BF_BIT_VMODE_ERR_STATUS,
                                                  `BF_BIT_FEATURE_ERR_STATUS, `BF_BIT_EXTRA_FUNCTION_REGS,
                                                  `BF_BIT_FAST_BUS_CAPABLE, `BF_BIT_POWER_CTRL,
                                                  `BF_BIT_SINGLE_CAPTURE, `BF_BIT_MULTI_CAPTURE};
  localparam logic [7:0]  FLAG_EXP           = 8'h4F;

  genvar fi;
  generate
    for (fi = 0; fi < FLAG_NUM; fi++)
    begin : g_flag
      property p_flag;
        @(posedge mclk_in) disable iff (sys_rst_in)
        s_basic_read |=> resp_rdata_out[31-FLAG_POS[fi]] == FLAG_EXP[fi];
      endproperty
      a_flag: assert property (p_flag) else $error("basic flag bit wrong"); // R5 R6 R7 R8
    end
  endgenerate

endmodule

// *** hw/inq_params.svh ***
// Offsets, field positions and fixed values of the capability inquiry words.
// Assumes byte offsets from the base of the initial register space.
`ifndef INQ_PARAMS_SVH
`define INQ_PARAMS_SVH

// Byte offsets of the inquiry words
`define OFS_RATE_SUPPORT_MONO16_MID   12'h258
`define OFS_RATE_SUPPORT_MONO16_HIGH  12'h25C
`define OFS_CUSTOM_MODE0_BLOCK_OFFSET 12'h2E0
`define OFS_CUSTOM_MODE1_BLOCK_OFFSET 12'h2E4
`define OFS_BASIC_FUNCTION_PRESENCE   12'h400

// Field positions, counted from the most significant bit as bit 0
`define RATE_BIT_1P875                0
`define RATE_BIT_3P75                 1
`define RATE_BIT_7P5                  2
`define RATE_BIT_15                   3
`define RATE_BIT_30                   4
`define RATE_BIT_60                   5
`define BF_BIT_VENDOR_EXT             0
`define BF_BIT_VMODE_ERR_STATUS       1
`define BF_BIT_FEATURE_ERR_STATUS     2
`define BF_BIT_EXTRA_FUNCTION_REGS    3
`define BF_BIT_FAST_BUS_CAPABLE       8
`define BF_BIT_POWER_CTRL             16
`define BF_BIT_SINGLE_CAPTURE         19
`define BF_BIT_MULTI_CAPTURE          20
`define BF_SLOT_FIRST                 28
`define BF_SLOT_LAST                  31

// Fixed values
`define BF_SLOT_MAX                   4'h3
`define CUSTOM0_OFS_DEFAULT           32'h0000_1000
`define CUSTOM1_OFS_DEFAULT           32'h0000_1100
`define WORD_ZERO                     32'h0000_0000

`endif

// *** hw/inq_pkg.sv ***
// Types shared by the capability inquiry register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package inq_pkg;

  // Which inquiry word a request selects
  typedef enum logic [2:0]
  {
    SEL_NONE,
    SEL_RATE_MID,
    SEL_RATE_HIGH,
    SEL_CUSTOM0,
    SEL_CUSTOM1,
    SEL_BASIC
  } inq_sel_t;

endpackage

// *** test/camera_capability_inquiry_regs_test.sv ***
// Self-checking bench of the capability inquiry bank, host model in front.
// Assumes the answer follows the taking edge by one cycle and stands one cycle.
`timescale 1ns/1ns

module camera_capability_inquiry_regs_test;
  localparam logic [31:0] OFS0 = 32'h0000_2A40;
  localparam logic [31:0] OFS1 = 32'h0000_2B00;
  logic        mclk_in = 1'b0;
  logic        sys_rst_in;
  logic        req_valid;
  logic        req_write;
  logic [11:0] req_addr;
  logic        resp_valid_out;
  logic        resp_write_out;
  logic        resp_error_out;
  logic [31:0] resp_rdata_out;
  logic        mono_valid;
  logic        mono_write;
  logic        mono_error;
  logic [31:0] mono_rdata;
  logic [33:0] notes[$];
  logic [33:0] note;
  logic [11:0] addr_tab[12] = '{12'h258, 12'h25C, 12'h2E0, 12'h2E4, 12'h400, 12'h259,
                                12'h25A, 12'h2E2, 12'h404, 12'h254, 12'h000, 12'hFFF};
  int          num_errors = 0;
  int          checked = 0;
  int          cycles = 0;
  int unsigned r;

  inq_host_model #(.ADDR_W(12)) i_host (.mclk_in(mclk_in), .req_valid_out(req_valid),
    .req_write_out(req_write), .req_addr_out(req_addr));

  camera_capability_inquiry_regs #(.ADDR_W(12), .CUSTOM0_OFS(OFS0), .CUSTOM1_OFS(OFS1), .COLOUR_MODEL(1'b1))
    i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid), .req_write_in(req_write),
    .req_addr_in(req_addr), .resp_valid_out(resp_valid_out), .resp_write_out(resp_write_out),
    .resp_error_out(resp_error_out), .resp_rdata_out(resp_rdata_out));

  // Mono build beside it, so the absent mode 1 word is exercised too
  camera_capability_inquiry_regs #(.ADDR_W(12), .CUSTOM0_OFS(OFS0), .CUSTOM1_OFS(OFS1), .COLOUR_MODEL(1'b0))
    i_dut_mono (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid), .req_write_in(req_write),
    .req_addr_in(req_addr), .resp_valid_out(mono_valid), .resp_write_out(mono_write),
    .resp_error_out(mono_error), .resp_rdata_out(mono_rdata));

  initial
  begin
    forever #50 mclk_in = ~mclk_in;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask

  task automatic end_sim();
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Note is {write, error, data}; writes return zero data and store nothing
  function automatic logic [33:0] expect_note(input logic write, input logic [11:0] addr);
    logic        err;
    logic [31:0] d;
    err = 1'b0;
    case (addr)
      12'h258, 12'h25C: d = 32'hE000_0000;
      12'h2E0:          d = OFS0;
      12'h2E4:          d = OFS1;
      12'h400:          d = 32'hF000_1003;
      default:
      begin
        d   = 32'h0000_0000;
        err = 1'b1;
      end
    endcase
    if (write)
      d = 32'h0000_0000;
    return {write, err, d};
  endfunction

  task automatic req(input logic write, input logic [11:0] addr);
    notes.push_back(expect_note(write, addr));
    i_host.send(write, addr);
  endtask

  // Settled values are looked at mid-cycle, away from the launching edge
  always @(negedge mclk_in)
  begin
    if (resp_valid_out === 1'b1)
    begin
      if (notes.size() == 0)
        check("unrequested answer", 32'h1, 32'h0);
      else
      begin
        note = notes.pop_front();
        check("resp_write_out", {31'h0, resp_write_out}, {31'h0, note[33]});
        check("resp_error_out", {31'h0, resp_error_out}, {31'h0, note[32]});
        check("resp_rdata_out", resp_rdata_out, note[31:0]);
        check("mono resp_valid_out", {31'h0, mono_valid}, 32'h1);
        check("mono resp_write_out", {31'h0, mono_write}, {31'h0, note[33]});
        check("mono resp_error_out", {31'h0, mono_error}, {31'h0, note[32]});
        check("mono resp_rdata_out", mono_rdata, (note[31:0] == OFS1) ? 32'h0 : note[31:0]);
        if (note[31:0] == 32'hF000_1003)
          check("slot count", {28'h0, i_host.slot_count(resp_rdata_out)}, 32'h3);
      end
    end
    else
    begin
      check("idle flags", {29'h0, mono_valid, resp_write_out, resp_error_out}, 32'h0);
      check("idle data", resp_rdata_out, 32'h0);
    end
  end

  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      end_sim();
    end
  end

  initial
  begin
    sys_rst_in = 1'b1;
    r = $urandom(11);
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    // Reads, then writes everywhere, then reads again: nothing may change
    for (int pass = 0; pass < 3; pass++)
      foreach (addr_tab[i])
        req(pass == 1, addr_tab[i]);
    repeat (400)
    begin
      r = $urandom();
      req(r[4], r[0] ? addr_tab[r[3:1] % 12] : r[31:20]);
      if (r[5])
        i_host.rest();
    end
    i_host.rest();
    // Reset in mid-run, then the words must read the same again
    @(posedge mclk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    foreach (addr_tab[i])
      req(1'b0, addr_tab[i]);
    repeat (3) i_host.rest();
    check("pending answers", notes.size(), 32'h0);
    end_sim();
  end
endmodule

// *** test/inq_host_model.sv ***
// Host side of the serial bus: issues quadlet reads and writes to the inquiry bank.
// Assumes the bench calls its tasks in order, one request per clock at most.
`timescale 1ns/1ns

module inq_host_model
#(
  parameter int ADDR_W = 12
)
(
  // Clock
  input  wire logic              mclk_in,
  // Quadlet request
  output logic                   req_valid_out,
  output logic                   req_write_out,
  output logic [ADDR_W-1:0]      req_addr_out
);
  initial
  begin
    req_valid_out = 1'b0;
    req_write_out = 1'b0;
    req_addr_out  = '0;
  end

  task automatic send(input logic write, input logic [ADDR_W-1:0] addr);
    @(posedge mclk_in);
    req_valid_out <= 1'b1;
    req_write_out <= write;
    req_addr_out  <= addr;
  endtask

  // Idle lines are scrambled so a stale address can never pass for a request
  task automatic rest();
    @(posedge mclk_in);
    req_valid_out <= 1'b0;
    req_write_out <= ~req_write_out;
    req_addr_out  <= ~req_addr_out;
  endtask

  // Zero in the slot field means no stored setting slots at all
  function automatic logic [3:0] slot_count(input logic [31:0] word);
    return word[3:0];
  endfunction
endmodule
